/* File: sar_adc_top.sv */
/*
 * Control of an 8-bit successive-approximation converter with six inputs:
 * Avalon-MM register slave, mode control, results per channel, interrupt.
 * Assumes an external comparator and analog multiplexer driven by the
 * dac code and channel outputs; cmp_in is asynchronous to clk_in.
 */
//
// Contract
// - Eight result bits decided MSB first
// - Reference-connect bit isolates resistor ladder
// - Result lands in converted channel's register
// - Conversion clock divides by one, two, four
// - Conversion lasts 49 or 28 ticks
// - Five modes selectable; one-shot, repeat implemented
// - Exactly one of six channels converted
// - Only a software start flag rise starts
// - One-shot stops after a single conversion
// - Writing start flag zero aborts conversion
// - One-shot completion raises an interrupt
// - Repeat converts continuously without interrupts
// - Sample-and-hold enable bit, set before start
`timescale 1ns/1ns
module sar_adc_top
   import sar_pkg::*;
#(
   parameter int NUM_CH = CH_COUNT
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Avalon-MM slave
   input wire logic [11:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   // Analog front end
   input wire logic cmp_in,
   output logic [7:0] dac_code_out,
   output logic [2:0] analog_input_channel_out,
   output logic vref_connect_out,
   output logic sample_hold_out,
   // Interrupt
   output logic irq_out
);
   // A count of 1 << CH_W would wrap to zero in the 3-bit channel range test
   if (NUM_CH < 1 || NUM_CH >= (1 << CH_W)) begin : g_bad_ch
      $error("NUM_CH outside the range the channel field can address");
   end

   typedef struct packed {
      logic wreq;
      logic [7:0] rdata;
      logic [2:0] ch;
      logic [2:0] mode;
      logic start;
      logic [1:0] div;
      logic vref;
      logic sh;
      logic status;
      logic mask;
      logic irq;
      logic [2:0] conv_ch;
      logic sar_start;
      logic sar_abort;
      logic cmp_s1;
      logic cmp_s2;
      logic [NUM_CH-1:0][7:0] res;
   } sar_top_state_t;
   sar_top_state_t q;
   sar_top_state_t next_q;

   sar_conv_if conv ();
   logic tick;

   // Repeat-style modes restart at each completion and never interrupt
   function automatic logic mode_repeats(input logic [2:0] m);
      case (m)
         MODE_REPEAT: mode_repeats = 1'b1;
         MODE_RSWEEP0: mode_repeats = 1'b1;
         MODE_RSWEEP1: mode_repeats = 1'b1;
         default: mode_repeats = 1'b0;
      endcase
   endfunction : mode_repeats

   function automatic logic is_result(input logic [9:0] idx);
      is_result = (idx >= IDX_RESULT0) && (idx < IDX_RESULT0 + 10'(NUM_CH));
   endfunction : is_result

   function automatic logic [7:0] read_reg(input sar_top_state_t s, input logic [9:0] idx,
                                           input logic busy);
      logic [9:0] slot;
      logic [7:0] v;
      slot = idx - IDX_RESULT0;
      v = 8'h00;
      if (is_result(idx)) begin
         v = s.res[slot[CH_W-1:0]];
      end else begin
         case (idx)
            IDX_CTRL0: begin
               v[CTRL0_CH_LSB +: 3] = s.ch;
               v[CTRL0_MODE_LSB +: 3] = s.mode;
               v[CTRL0_START_BIT] = s.start;
               v[CTRL0_BUSY_BIT] = busy;
            end
            IDX_CTRL1: begin
               v[CTRL1_DIV_LSB +: 2] = s.div;
               v[CTRL1_VREF_BIT] = s.vref;
            end
            IDX_CTRL2: v[CTRL2_SH_BIT] = s.sh;
            IDX_STATUS: v[STATUS_DONE_BIT] = s.status;
            IDX_MASK: v[STATUS_DONE_BIT] = s.mask;
            default: v = 8'h00;
         endcase
      end
      return v;
   endfunction : read_reg

   logic [9:0] idx;
   logic [7:0] wd;
   logic wr;
   logic irq_set;
   logic status_clr;
   logic start_prev;
   logic wr_ctrl0;

   always_comb begin
      next_q = q;
      idx = avs_address_in[11:2];
      wd = avs_writedata_in[7:0];
      // The write takes effect at the edge where waitrequest is seen low
      wr = avs_write_in && !q.wreq && avs_byteenable_in[0];
      wr_ctrl0 = wr && (idx == IDX_CTRL0);
      irq_set = 1'b0;
      status_clr = 1'b0;
      next_q.sar_start = 1'b0;
      next_q.sar_abort = 1'b0;
      next_q.cmp_s1 = cmp_in;
      next_q.cmp_s2 = q.cmp_s1;
      next_q.wreq = !((avs_read_in || avs_write_in) && q.wreq);
      if (avs_read_in && q.wreq) begin
         next_q.rdata = read_reg(q, idx, conv.busy);
      end
      if (conv.done) begin
         next_q.res[q.conv_ch] = conv.result;
         if (q.start) begin
            if (mode_repeats(q.mode)) begin
               next_q.sar_start = 1'b1;
               next_q.conv_ch = q.ch;
            end else begin
               next_q.start = 1'b0;
               irq_set = 1'b1;
            end
         end
      end
      start_prev = next_q.start;
      if (wr) begin
         case (idx)
            IDX_CTRL0: begin
               // Out-of-range channel codes are ignored, keeping the last valid one
               if (wd[CTRL0_CH_LSB +: 3] < 3'(NUM_CH)) begin
                  next_q.ch = wd[CTRL0_CH_LSB +: 3];
               end
               next_q.mode = wd[CTRL0_MODE_LSB +: 3];
               next_q.start = wd[CTRL0_START_BIT];
               if (wd[CTRL0_START_BIT] && !start_prev) begin
                  next_q.sar_start = 1'b1;
                  next_q.conv_ch = next_q.ch;
               end
               if (!wd[CTRL0_START_BIT]) begin
                  next_q.sar_start = 1'b0;
                  next_q.sar_abort = 1'b1;
               end
            end
            IDX_CTRL1: begin
               next_q.div = wd[CTRL1_DIV_LSB +: 2];
               next_q.vref = wd[CTRL1_VREF_BIT];
            end
            IDX_CTRL2: next_q.sh = wd[CTRL2_SH_BIT];
            IDX_STATUS: status_clr = wd[STATUS_DONE_BIT];
            IDX_MASK: next_q.mask = wd[STATUS_DONE_BIT];
            default: next_q.start = next_q.start;
         endcase
      end
      // A completion in the clearing cycle is kept
      next_q.status = (q.status && !status_clr) || irq_set;
      next_q.irq = next_q.status && next_q.mask;
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
         q.wreq <= 1'b1;
         q.ch <= CH_RST;
         q.mode <= MODE_ONESHOT;
         q.div <= DIV_RST;
         q.vref <= VREF_RST;
         q.sh <= SH_RST;
         q.mask <= MASK_RST;
      end else begin
         q <= next_q;
      end
   end

   sar_clk_div u_div (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .sel_in(q.div),
      .tick_out(tick)
   );

   assign conv.tick = tick;
   assign conv.start = q.sar_start;
   assign conv.abort = q.sar_abort;
   assign conv.sh_en = q.sh;
   assign conv.cmp = q.cmp_s2;

   sar_conv_core u_core (
      .clk_in(clk_in),
      .rstn_in(rstn_in),
      .conv(conv)
   );

   assign avs_readdata_out = {24'h000000, q.rdata};
   assign avs_waitrequest_out = q.wreq;
   assign dac_code_out = conv.dac;
   assign analog_input_channel_out = q.conv_ch;
   assign vref_connect_out = q.vref;
   assign sample_hold_out = q.sh;
   assign irq_out = q.irq;

   sequence s_oneshot_end;
      conv.done && q.start && !mode_repeats(q.mode) && !wr_ctrl0;
   endsequence
   sequence s_repeat_end;
      conv.done && q.start && mode_repeats(q.mode) && !wr;
   endsequence

   property p_result_store;
      @(posedge clk_in) disable iff (!rstn_in)
      conv.done |=> q.res[$past(q.conv_ch)] == $past(conv.result);
   endproperty
   a_result_store: assert property (p_result_store) else $error("result not stored");

   property p_oneshot_stop;
      @(posedge clk_in) disable iff (!rstn_in)
      s_oneshot_end |=> !q.start && !q.sar_start ##1 !conv.busy;
   endproperty
   a_oneshot_stop: assert property (p_oneshot_stop) else $error("one-shot kept running");

   property p_oneshot_irq;
      @(posedge clk_in) disable iff (!rstn_in)
      s_oneshot_end |=> q.status && (q.irq == q.mask);
   endproperty
   a_oneshot_irq: assert property (p_oneshot_irq) else $error("one-shot no interrupt");

   property p_repeat_go;
      @(posedge clk_in) disable iff (!rstn_in)
      s_repeat_end |=> q.sar_start && q.start && q.status == $past(q.status) ##1 conv.busy;
   endproperty
   a_repeat_go: assert property (p_repeat_go) else $error("repeat did not restart");

   property p_abort;
      @(posedge clk_in) disable iff (!rstn_in)
      (wr_ctrl0 && !wd[CTRL0_START_BIT]) |=> q.sar_abort && !q.start ##1 !conv.busy;
   endproperty
   a_abort: assert property (p_abort) else $error("abort did not stop");

   property p_sw_start;
      @(posedge clk_in) disable iff (!rstn_in)
      $rose(conv.busy) |-> $past(q.sar_start) && q.start;
   endproperty
   a_sw_start: assert property (p_sw_start) else $error("start without software");

   property p_vref;
      @(posedge clk_in) disable iff (!rstn_in)
      (wr && idx == IDX_CTRL1) |=> vref_connect_out == $past(wd[CTRL1_VREF_BIT]);
   endproperty
   a_vref: assert property (p_vref) else $error("reference connect wrong");

   property p_ch_range;
      @(posedge clk_in) disable iff (!rstn_in)
      conv.busy |-> (q.conv_ch < 3'(NUM_CH)) && $stable(q.conv_ch);
   endproperty
   a_ch_range: assert property (p_ch_range) else $error("channel changed or bad");

   property p_status_hold;
      @(posedge clk_in) disable iff (!rstn_in)
      q.status && !(wr && idx == IDX_STATUS && wd[STATUS_DONE_BIT]) |=> q.status;
   endproperty
   a_status_hold: assert property (p_status_hold) else $error("status lost");

   property p_abort_dac;
      @(posedge clk_in) disable iff (!rstn_in)
      (wr_ctrl0 && !wd[CTRL0_START_BIT]) |=> ##1 dac_code_out == 8'h00;
   endproperty
   a_abort_dac: assert property (p_abort_dac) else $error("abort left a trial code");

   // Exactly one wait cycle per access, then back to the idle level
   property p_one_wait;
      @(posedge clk_in) disable iff (!rstn_in)
      (avs_read_in || avs_write_in) && avs_waitrequest_out
      |=> !avs_waitrequest_out ##1 avs_waitrequest_out;
   endproperty
   a_one_wait: assert property (p_one_wait) else $error("wait cycle count wrong");
endmodule : sar_adc_top

/* File: sar_pkg.sv */
/*
 * Shared constants and types of the successive-approximation converter control.
 * Assumes word-aligned Avalon-MM byte addresses: byte address = 4 x register index.
 */
package sar_pkg;
   localparam int DATA_W = 8;
   localparam int CH_COUNT = 6;
   localparam int CH_W = 3;
   // Register indices
   localparam logic [9:0] IDX_RESULT0 = 10'h3C0;
   localparam logic [9:0] IDX_STATUS = 10'h3D0;
   localparam logic [9:0] IDX_MASK = 10'h3D1;
   localparam logic [9:0] IDX_CTRL2 = 10'h3D4;
   localparam logic [9:0] IDX_CTRL0 = 10'h3D6;
   localparam logic [9:0] IDX_CTRL1 = 10'h3D7;
   // Field positions
   localparam int CTRL0_CH_LSB = 0;
   localparam int CTRL0_MODE_LSB = 3;
   localparam int CTRL0_START_BIT = 6;
   localparam int CTRL0_BUSY_BIT = 7;
   localparam int CTRL1_DIV_LSB = 0;
   localparam int CTRL1_VREF_BIT = 5;
   localparam int CTRL2_SH_BIT = 0;
   localparam int STATUS_DONE_BIT = 0;
   // Reset values
   localparam logic [2:0] CH_RST = 3'h0;
   localparam logic [1:0] DIV_RST = 2'h0;
   localparam logic VREF_RST = 1'b0;
   localparam logic SH_RST = 1'b0;
   localparam logic MASK_RST = 1'b0;
   // Conversion timing in conversion-clock ticks, and the first trial code
   localparam logic [6:0] CYC_NO_SH = 7'h31;
   localparam logic [6:0] CYC_SH = 7'h1C;
   localparam logic [6:0] SAR_TAIL = 7'h19;
   localparam logic [1:0] PH_DECIDE = 2'h2;
   localparam logic [7:0] DAC_MSB = 8'h80;
   typedef enum logic [2:0] {
      MODE_ONESHOT = 3'b000,
      MODE_REPEAT = 3'b001,
      MODE_SSWEEP = 3'b010,
      MODE_RSWEEP0 = 3'b011,
      MODE_RSWEEP1 = 3'b100
   } sar_mode_t;
   typedef enum logic [1:0] {
      DIV_1 = 2'b00,
      DIV_2 = 2'b01,
      DIV_4 = 2'b10
   } sar_div_t;
endpackage : sar_pkg

/* File: sar_conv_if.sv */
/*
 * Carrier between the register side and the conversion sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ns
interface sar_conv_if;
   logic tick;
   logic start;
   logic abort;
   logic sh_en;
   logic cmp;
   logic busy;
   logic done;
   logic [7:0] result;
   logic [7:0] dac;
   modport ctrl (output tick, start, abort, sh_en, cmp, input busy, done, result, dac);
   modport conv (input tick, start, abort, sh_en, cmp, output busy, done, result, dac);
endinterface : sar_conv_if

/* File: sar_clk_div.sv */
/*
 * Conversion-clock enable: one-cycle tick at clk, clk/2 or clk/4.
 * Assumes the select is changed only while the converter is idle.
 */
`timescale 1ns/1ns
module sar_clk_div
   import sar_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Divider
   input wire logic [1:0] sel_in,
   output logic tick_out
);
   typedef struct packed {
      logic [1:0] cnt;
      logic tick;
   } sar_div_state_t;
   sar_div_state_t q;
   sar_div_state_t next_q;

   always_comb begin
      next_q = q;
      next_q.cnt = q.cnt + 2'h1;
      case (sel_in)
         DIV_1: next_q.tick = 1'b1;
         DIV_2: next_q.tick = q.cnt[0];
         default: next_q.tick = (q.cnt == 2'h3);
      endcase
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign tick_out = q.tick;

   property p_div4_gap;
      @(posedge clk_in) disable iff (!rstn_in)
      (q.tick && sel_in == DIV_4) ##1 (sel_in == DIV_4 && !q.tick) [*3] |=> q.tick;
   endproperty
   a_div4_gap: assert property (p_div4_gap) else $error("div4 tick spacing wrong");
endmodule : sar_clk_div

/* File: sar_conv_core.sv */
/*
 * Successive-approximation sequencer: sampling phase, then eight bit trials.
 * Assumes cmp is already synchronised and is high when input >= dac code.
 */
`timescale 1ns/1ns
module sar_conv_core
   import sar_pkg::*;
(
   // Clock and reset
   input wire logic clk_in,
   input wire logic rstn_in,
   // Conversion control
   sar_conv_if.conv conv
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_BITS = 2'b10
   } sar_core_st_t;
   typedef struct packed {
      sar_core_st_t st;
      logic [6:0] cnt;
      logic [1:0] ph;
      logic [2:0] bit_idx;
      logic [7:0] dac;
      logic [7:0] result;
      logic done;
      logic sh;
   } sar_core_state_t;
   sar_core_state_t q;
   sar_core_state_t next_q;
   logic [6:0] total;
   logic [2:0] idx_m1;

   // Three ticks per bit leave room for the comparator synchroniser at clk/1
   always_comb begin
      next_q = q;
      next_q.done = 1'b0;
      total = q.sh ? CYC_SH : CYC_NO_SH;
      idx_m1 = q.bit_idx - 3'h1;
      case (q.st)
         ST_IDLE: begin
            next_q.ph = 2'h0;
         end
         ST_SAMPLE: begin
            if (conv.tick) begin
               next_q.cnt = q.cnt + 7'h01;
               if (q.cnt == total - SAR_TAIL) begin
                  next_q.st = ST_BITS;
                  next_q.dac = DAC_MSB;
                  next_q.bit_idx = 3'h7;
                  next_q.ph = 2'h0;
               end
            end
         end
         ST_BITS: begin
            if (conv.tick) begin
               if (q.ph == PH_DECIDE) begin
                  next_q.ph = 2'h0;
                  if (!conv.cmp) begin
                     next_q.dac[q.bit_idx] = 1'b0;
                  end
                  if (q.bit_idx == 3'h0) begin
                     next_q.result = next_q.dac;
                     next_q.done = 1'b1;
                     next_q.st = ST_IDLE;
                  end else begin
                     next_q.bit_idx = idx_m1;
                     next_q.dac[idx_m1] = 1'b1;
                  end
               end else begin
                  next_q.ph = q.ph + 2'h1;
               end
            end
         end
         default: begin
            next_q.st = ST_IDLE;
         end
      endcase
      if (conv.start) begin
         next_q.st = ST_SAMPLE;
         next_q.cnt = 7'h00;
         next_q.sh = conv.sh_en;
         next_q.dac = 8'h00;
      end
      if (conv.abort) begin
         next_q.st = ST_IDLE;
         next_q.dac = 8'h00;
         next_q.done = 1'b0;
      end
   end

   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         q <= '0;
      end else begin
         q <= next_q;
      end
   end

   assign conv.busy = (q.st != ST_IDLE);
   assign conv.done = q.done;
   assign conv.result = q.result;
   assign conv.dac = q.dac;

   // Helper: conversion ticks seen since the last start
   logic [6:0] tick_seen;
   always_ff @(posedge clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         tick_seen <= 7'h00;
      end else if (conv.start) begin
         tick_seen <= 7'h00;
      end else if (conv.tick && conv.busy) begin
         tick_seen <= tick_seen + 7'h01;
      end
   end

   property p_conv_len;
      @(posedge clk_in) disable iff (!rstn_in)
      q.done |-> tick_seen == (q.sh ? CYC_SH : CYC_NO_SH);
   endproperty
   a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

   sequence s_enter_bits;
      $rose(q.st == ST_BITS);
   endsequence
   property p_msb_trial;
      @(posedge clk_in) disable iff (!rstn_in)
      s_enter_bits |-> q.dac == DAC_MSB && q.bit_idx == 3'h7;
   endproperty
   a_msb_trial: assert property (p_msb_trial) else $error("first trial not msb");

   property p_bit_step;
      @(posedge clk_in) disable iff (!rstn_in)
      (q.st == ST_BITS && conv.tick && q.ph == PH_DECIDE && q.bit_idx != 3'h0
       && !conv.start && !conv.abort) |=> q.bit_idx == $past(q.bit_idx) - 3'h1;
   endproperty
   a_bit_step: assert property (p_bit_step) else $error("bit order wrong");
endmodule : sar_conv_core

/* File: sar_analog_src.sv */
/*
 * Analog side seen by the converter: six input levels and the comparator.
 * Assumes the bench sets the levels; the design synchronises cmp_out itself.
 */
`timescale 1ns/1ns
module sar_analog_src (
   // Clock
   input wire logic clk_in,
   // Levels from the bench
   input wire logic [47:0] level_in,
   // Converter pins
   input wire logic [7:0] dac_code_in,
   input wire logic [2:0] channel_in,
   input wire logic vref_connect_in,
   output logic cmp_out
);
   logic junk = 1'b0;
   logic [7:0] lvl;

   // Meaningless comparator output flips every cycle so a stale value never reads as valid
   always_ff @(posedge clk_in) begin
      junk <= ~junk;
   end

   assign lvl = level_in[channel_in * 8 +: 8];
   // Isolated ladder gives no usable compare
   assign cmp_out = (vref_connect_in && channel_in < 3'h6) ? (lvl >= dac_code_in) : junk;
endmodule : sar_analog_src

/* File: test_sar_adc_oneshot_repeat_ctrl.sv */
/*
 * Self-checking bench: register accesses over Avalon-MM, conversions checked
 * against the analog levels. Assumes sar_pkg, the design and sar_analog_src.
 */
`timescale 1ns/1ns
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got %0h exp %0h", $time, (got), (exp)); end end
module test_sar_adc_oneshot_repeat_ctrl
   import sar_pkg::*;
;
   logic clk_in;
   logic rstn_in;
   logic [11:0] avs_address_in;
   logic avs_read_in;
   logic avs_write_in;
   logic [31:0] avs_writedata_in;
   logic [3:0] avs_byteenable_in;
   logic [31:0] avs_readdata_out;
   logic avs_waitrequest_out;
   logic cmp_in;
   logic [7:0] dac_code_out;
   logic [2:0] analog_input_channel_out;
   logic vref_connect_out;
   logic sample_hold_out;
   logic irq_out;
   logic [47:0] level_bus;
   logic [7:0] q;
   int fail_count;
   int checks_done;
   int i;
   int n;
   int tk;
   int f;

   sar_adc_top u_sar_adc_top (.clk_in(clk_in), .rstn_in(rstn_in),
      .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
      .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
      .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
      .avs_waitrequest_out(avs_waitrequest_out), .cmp_in(cmp_in),
      .dac_code_out(dac_code_out), .analog_input_channel_out(analog_input_channel_out),
      .vref_connect_out(vref_connect_out), .sample_hold_out(sample_hold_out),
      .irq_out(irq_out));

   sar_analog_src u_sar_analog_src (.clk_in(clk_in), .level_in(level_bus),
      .dac_code_in(dac_code_out), .channel_in(analog_input_channel_out),
      .vref_connect_in(vref_connect_out), .cmp_out(cmp_in));

   task automatic results();
      $display("checks %0d failures %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : results

   function automatic logic [7:0] ctl(input logic s, input logic [2:0] m, input logic [2:0] c);
      return {1'b0, s, m, c};
   endfunction : ctl

   // One access; request held until waitrequest is seen low at a rising edge
   task automatic bus(input logic wr, input logic [9:0] idx, input logic [7:0] d,
                      output logic [7:0] rq);
      int k;
      k = 0;
      @(posedge clk_in);
      avs_address_in <= {idx, 2'b00};
      avs_writedata_in <= {24'h000000, d};
      avs_write_in <= wr;
      avs_read_in <= ~wr;
      do begin
         @(posedge clk_in);
         k++;
      end while (avs_waitrequest_out !== 1'b0 && k < 100);
      rq = avs_readdata_out[7:0];
      avs_write_in <= 1'b0;
      avs_read_in <= 1'b0;
      if (k >= 100) begin
         fail_count++;
         results();
      end
   endtask : bus

   task automatic wr(input logic [9:0] idx, input logic [7:0] d);
      logic [7:0] dummy;
      bus(1'b1, idx, d, dummy);
   endtask : wr

   task automatic rd_chk(input logic [9:0] idx, input logic [7:0] exp);
      logic [7:0] rq;
      bus(1'b0, idx, 8'h00, rq);
      `CHK(rq, exp);
   endtask : rd_chk

   // Reads until the expected value shows; bounded
   task automatic poll(input logic [9:0] idx, input logic [7:0] exp);
      logic [7:0] rq;
      int k;
      k = 0;
      do begin
         bus(1'b0, idx, 8'h00, rq);
         k++;
      end while (rq !== exp && k < 200);
      `CHK(rq, exp);
      if (rq !== exp) results();
   endtask : poll

   task automatic settle();
      @(negedge clk_in);
   endtask : settle

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   initial begin
      rstn_in = 1'b0;
      avs_address_in = 12'h000;
      avs_read_in = 1'b0;
      avs_write_in = 1'b0;
      avs_writedata_in = 32'h00000000;
      avs_byteenable_in = 4'hF;
      level_bus = {8'hAA, 8'h55, 8'h7F, 8'h80, 8'hFF, 8'h00};
      fail_count = 0;
      checks_done = 0;
      repeat (6) @(posedge clk_in);
      rstn_in <= 1'b1;
      settle();
      `CHK(vref_connect_out, 1'b0);
      `CHK(sample_hold_out, 1'b0);
      `CHK(irq_out, 1'b0);
      rd_chk(IDX_CTRL1, 8'h00);
      rd_chk(IDX_CTRL2, 8'h00);
      rd_chk(IDX_MASK, 8'h00);
      rd_chk(IDX_STATUS, 8'h00);
      rd_chk(10'h3FF, 8'h00);
      wr(IDX_RESULT0, 8'h5A);
      rd_chk(IDX_RESULT0, 8'h00);
      for (i = 0; i < 5; i++) begin
         wr(IDX_CTRL0, ctl(1'b0, 3'(i), 3'h3));
         rd_chk(IDX_CTRL0, ctl(1'b0, 3'(i), 3'h3));
      end
      wr(IDX_CTRL0, ctl(1'b0, MODE_RSWEEP1, 3'h6));
      rd_chk(IDX_CTRL0, ctl(1'b0, MODE_RSWEEP1, 3'h3));
      wr(IDX_MASK, 8'h01);
      // One-shot on every channel, every divider, both sample-and-hold settings
      for (i = 0; i < 6; i++) begin
         // The bench clock stands for a 250 MHz oscillator, so each divider stays legal
         wr(IDX_CTRL1, 8'h20 | 8'(i % 3));
         wr(IDX_CTRL2, 8'(i / 3));
         settle();
         `CHK(vref_connect_out, 1'b1);
         `CHK(sample_hold_out, 1'(i / 3));
         wr(IDX_CTRL0, ctl(1'b1, MODE_ONESHOT, 3'(i)));
         n = 0;
         while (irq_out !== 1'b1 && n < 1000) begin
            @(posedge clk_in);
            n++;
         end
         tk = (i / 3) ? 28 : 49;
         f = 1 << (i % 3);
         `CHK(n >= (tk - 1) * f && n <= tk * f + f + 8, 1'b1);
         if (n >= 1000) results();
         `CHK(analog_input_channel_out, 3'(i));
         rd_chk(IDX_RESULT0 + 10'(i), level_bus[i * 8 +: 8]);
         rd_chk(IDX_CTRL0, ctl(1'b0, MODE_ONESHOT, 3'(i)));
         rd_chk(IDX_STATUS, 8'h01);
         wr(IDX_STATUS, 8'h01);
         settle();
         `CHK(irq_out, 1'b0);
      end
      for (i = 0; i < 6; i++) begin
         rd_chk(IDX_RESULT0 + 10'(i), level_bus[i * 8 +: 8]);
      end
      // Repeat mode keeps following the input, silently
      wr(IDX_CTRL1, 8'h20);
      wr(IDX_CTRL2, 8'h01);
      wr(IDX_CTRL0, ctl(1'b1, MODE_REPEAT, 3'h2));
      level_bus[23:16] <= 8'h3C;
      poll(IDX_RESULT0 + 10'h002, 8'h3C);
      level_bus[23:16] <= 8'hC3;
      poll(IDX_RESULT0 + 10'h002, 8'hC3);
      rd_chk(IDX_STATUS, 8'h00);
      settle();
      `CHK(irq_out, 1'b0);
      bus(1'b0, IDX_CTRL0, 8'h00, q);
      `CHK(q[6], 1'b1);
      wr(IDX_CTRL0, ctl(1'b0, MODE_REPEAT, 3'h2));
      level_bus[23:16] <= 8'h11;
      repeat (300) @(posedge clk_in);
      rd_chk(IDX_RESULT0 + 10'h002, 8'hC3);
      rd_chk(IDX_CTRL0, ctl(1'b0, MODE_REPEAT, 3'h2));
      // One-shot aborted during its sampling phase leaves no result and no status
      wr(IDX_CTRL1, 8'h22);
      wr(IDX_CTRL2, 8'h00);
      level_bus[39:32] <= 8'h42;
      wr(IDX_CTRL0, ctl(1'b1, MODE_ONESHOT, 3'h4));
      repeat (20) @(posedge clk_in);
      wr(IDX_CTRL0, ctl(1'b0, MODE_ONESHOT, 3'h4));
      repeat (300) @(posedge clk_in);
      `CHK(dac_code_out, 8'h00);
      rd_chk(IDX_RESULT0 + 10'h004, 8'h55);
      rd_chk(IDX_STATUS, 8'h00);
      // Masked completion: status sticks, interrupt follows the mask
      wr(IDX_MASK, 8'h00);
      wr(IDX_CTRL0, ctl(1'b1, MODE_ONESHOT, 3'h4));
      poll(IDX_CTRL0, ctl(1'b0, MODE_ONESHOT, 3'h4));
      rd_chk(IDX_RESULT0 + 10'h004, 8'h42);
      settle();
      `CHK(irq_out, 1'b0);
      rd_chk(IDX_STATUS, 8'h01);
      wr(IDX_MASK, 8'h01);
      settle();
      `CHK(irq_out, 1'b1);
      level_bus[39:32] <= 8'h24;
      repeat (300) @(posedge clk_in);
      rd_chk(IDX_RESULT0 + 10'h004, 8'h42);
      wr(IDX_STATUS, 8'h01);
      settle();
      `CHK(irq_out, 1'b0);
      results();
   end
endmodule : test_sar_adc_oneshot_repeat_ctrl
